/* hw/fsw_defines.svh */
// Opcodes, status bit positions and fixed counts of the flash status block.
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH
`define FSW_CMD_WRITE_STATUS 8'h01
`define FSW_CMD_PAGE_PROGRAM 8'h02
`define FSW_CMD_WRITE_DISABLE 8'h04
`define FSW_CMD_READ_STATUS 8'h05
`define FSW_CMD_WRITE_ENABLE 8'h06
`define FSW_CMD_READ_IDENT 8'h9f
`define FSW_CMD_QUAD_PAGE_PROGRAM 8'h38
`define FSW_CMD_SECTOR_ERASE 8'h20
`define FSW_CMD_CHIP_ERASE_A 8'h60
`define FSW_CMD_CHIP_ERASE_B 8'hc7
`define FSW_CMD_PROTECT_SELECT 8'h68
`define FSW_CMD_SECURITY_WRITE 8'h2f
`define FSW_CMD_SINGLE_LOCK 8'h36
`define FSW_CMD_SINGLE_UNLOCK 8'h39
`define FSW_CMD_GANG_LOCK 8'h7e
`define FSW_CMD_GANG_UNLOCK 8'h98
`define FSW_SR_WIP 0
`define FSW_SR_WEL 1
`define FSW_SR_BP_LO 2
`define FSW_SR_BP_HI 5
`define FSW_SR_QE 6
`define FSW_SR_LOCK 7
`define FSW_LAST_BIT 3'h7
`define FSW_BYTES_MAX 3'h7
`define FSW_BYTES_OPCODE 3'h1
`define FSW_BYTES_STATUS_WR 3'h2
`define FSW_BYTES_ADDR_CMD 3'h4
`define FSW_BYTES_ADDR_LAST 3'h3
`define FSW_CLK_NS 10
`define FSW_TW_NS 10000
`endif

/* hw/fsw_device.sv */
// Flash status register, write enable latch, identification and write protection.
// Notes on behaviour
// - Write disable opcode clears the write enable latch.
// - Latch cleared at power-up and command completion.
// - Identification returns three bytes after its opcode.
// - Host may end identification readout at any time.
// - Identification not decoded while program or erase runs.
// - Status read accepted at any time, byte shifted out.
// - Host polls write-in-progress before new commands.
// - Bit 0 shows write-in-progress while busy.
// - Program and erase ignored unless latch set.
// - Protected target: ignore command, clear latch.
// - Bits 5 to 2 are protection level.
// - Chip erase only with zero protection level.
// - Quad enable disables write-protect pin and hardware mode.
// - Lock bit with low pin rejects status writes.
// - Status write needs latch, leaves bits 1,0.
// - Status write rejected off a byte boundary.
// - Status write cycle starts at select rise.
// - Hardware mode holds until write-protect pin is high.
// - Otherwise software mode allows lock and level writes.
// - Write enable opcode sets the latch.
`timescale 1ns/1ns
`include "fsw_defines.svh"
module fsw_device #(
  parameter int TW_NS = `FSW_TW_NS,
  parameter logic [7:0] HALF_BLOCK_ERASE_OP = 8'h52,
  parameter logic [7:0] BLOCK_ERASE_OP = 8'hd8,
  // Identification values are arbitrary.
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] TYPE_ID = 8'h3c,
  parameter logic [7:0] DEV_ID = 8'h14
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  fsw_link_if.dev link,
  input wire logic pe_region_protected_in,
  input wire logic pe_done_in,
  output logic pe_start_out,
  output logic [7:0] pe_opcode_out,
  output logic [23:0] pe_addr_out,
  output logic [7:0] status_out,
  output logic hw_protect_out,
  output logic quad_mode_out
);
  localparam int TW_CYCLES_RAW = (TW_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS;
  localparam int TW_CYCLES = (TW_CYCLES_RAW < 1) ? 1 : TW_CYCLES_RAW;

  fsw_pkg::fsw_link_st_t lk_q;
  fsw_pkg::fsw_link_st_t lk_d;
  fsw_pkg::fsw_sys_st_t sy_q;
  fsw_pkg::fsw_sys_st_t sy_d;
  logic fresh_q;
  logic miso_q;
  logic frm_rst_n;
  logic [7:0] status_w;
  logic hpm_w;
  logic [7:0] byte_v;
  logic [2:0] bc;
  logic [2:0] byc;
  logic commit;
  logic on_boundary;
  logic is_addr_cmd;
  logic clr_only;

  function automatic logic [7:0] id_byte(input logic [2:0] idx);
    if (idx == `FSW_BYTES_OPCODE) begin
      id_byte = TYPE_ID;
    end else if (idx == `FSW_BYTES_STATUS_WR) begin
      id_byte = DEV_ID;
    end else begin
      id_byte = 8'h00;
    end
  endfunction : id_byte

  assign status_w = {sy_q.lock, sy_q.qe, sy_q.bp, sy_q.write_enable_latch,
                     sy_q.busy != fsw_pkg::FSW_BUSY_IDLE};
  assign hpm_w = sy_q.lock & ~sy_q.wp_s & ~sy_q.qe;
  assign status_out = status_w;
  assign hw_protect_out = hpm_w;
  assign quad_mode_out = sy_q.qe;
  assign pe_start_out = sy_q.pe_start;
  assign pe_opcode_out = sy_q.pe_op;
  assign pe_addr_out = sy_q.pe_addr;

  // Link side, clocked by the serial clock; a fresh frame restarts the counters.
  assign frm_rst_n = resetn_in & ~link.cs_n;
  always_ff @(posedge link.sck or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_comb begin
    lk_d = lk_q;
    byte_v = {lk_q.sh[6:0], link.mosi};
    bc = fresh_q ? 3'h0 : lk_q.bit_cnt;
    byc = fresh_q ? 3'h0 : lk_q.byte_cnt;
    if (fresh_q) begin
      lk_d.tgl = ~lk_q.tgl;
      lk_d.out_en = 1'b0;
    end
    lk_d.st_m = status_w;
    lk_d.st_s = lk_q.st_m;
    lk_d.sh = byte_v;
    lk_d.bit_cnt = bc + 3'h1;
    lk_d.byte_cnt = byc;
    lk_d.tx = {lk_q.tx[6:0], 1'b0};
    if (bc == `FSW_LAST_BIT) begin
      if (byc != `FSW_BYTES_MAX) begin
        lk_d.byte_cnt = byc + 3'h1;
      end
      if (byc == 3'h0) begin
        lk_d.op = byte_v;
        if (byte_v == `FSW_CMD_READ_STATUS) begin
          lk_d.out_en = 1'b1;
          lk_d.tx = lk_q.st_s;
        end else if (byte_v == `FSW_CMD_READ_IDENT && !lk_q.st_s[`FSW_SR_WIP]) begin
          lk_d.out_en = 1'b1;
          lk_d.tx = MFR_ID;
        end
      end else begin
        if (byc == `FSW_BYTES_OPCODE) begin
          lk_d.wdata = byte_v;
        end
        if (byc <= `FSW_BYTES_ADDR_LAST) begin
          lk_d.addr = {lk_q.addr[15:0], byte_v};
        end
        if (lk_q.op == `FSW_CMD_READ_STATUS) begin
          lk_d.tx = lk_q.st_s;
        end else begin
          lk_d.tx = id_byte(byc);
        end
      end
    end
  end

  always_ff @(posedge link.sck or negedge resetn_in) begin
    if (!resetn_in) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // Output bits change on the falling serial clock edge.
  always_ff @(negedge link.sck or negedge resetn_in) begin
    if (!resetn_in) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= lk_q.tx[7];
    end
  end

  assign link.miso_d = miso_q;
  assign link.miso_oe = lk_q.out_en & ~fresh_q & ~link.cs_n;

  // System side: commits each frame once select has risen.
  assign commit = sy_q.cs_s & ~sy_q.cs_p & (sy_q.tgl_s != sy_q.tgl_seen);
  assign on_boundary = lk_q.bit_cnt == 3'h0;
  assign is_addr_cmd = lk_q.op == `FSW_CMD_PAGE_PROGRAM || lk_q.op == `FSW_CMD_QUAD_PAGE_PROGRAM
                       || lk_q.op == `FSW_CMD_SECTOR_ERASE || lk_q.op == HALF_BLOCK_ERASE_OP
                       || lk_q.op == BLOCK_ERASE_OP;
  assign clr_only = lk_q.op == `FSW_CMD_PROTECT_SELECT || lk_q.op == `FSW_CMD_SECURITY_WRITE
                    || lk_q.op == `FSW_CMD_GANG_LOCK || lk_q.op == `FSW_CMD_GANG_UNLOCK
                    || lk_q.op == `FSW_CMD_SINGLE_LOCK || lk_q.op == `FSW_CMD_SINGLE_UNLOCK;

  always_comb begin
    sy_d = sy_q;
    sy_d.cs_m = link.cs_n;
    sy_d.cs_s = sy_q.cs_m;
    sy_d.cs_p = sy_q.cs_s;
    sy_d.wp_m = link.wp_n;
    sy_d.wp_s = sy_q.wp_m;
    sy_d.tgl_m = lk_q.tgl;
    sy_d.tgl_s = sy_q.tgl_m;
    sy_d.pe_start = 1'b0;
    if (commit) begin
      sy_d.tgl_seen = sy_q.tgl_s;
    end
    case (sy_q.busy)
      fsw_pkg::FSW_BUSY_STATUS: begin
        if (sy_q.timer == 24'h000000) begin
          sy_d.bp = sy_q.pend[`FSW_SR_BP_HI:`FSW_SR_BP_LO];
          sy_d.qe = sy_q.pend[`FSW_SR_QE];
          sy_d.lock = sy_q.pend[`FSW_SR_LOCK];
          sy_d.write_enable_latch = 1'b0;
          sy_d.busy = fsw_pkg::FSW_BUSY_IDLE;
        end else begin
          sy_d.timer = sy_q.timer - 24'h000001;
        end
      end
      fsw_pkg::FSW_BUSY_ARRAY: begin
        if (pe_done_in) begin
          sy_d.write_enable_latch = 1'b0;
          sy_d.busy = fsw_pkg::FSW_BUSY_IDLE;
        end
      end
      default: begin
        if (commit && on_boundary) begin
          if (lk_q.op == `FSW_CMD_WRITE_ENABLE && lk_q.byte_cnt == `FSW_BYTES_OPCODE) begin
            sy_d.write_enable_latch = 1'b1;
          end else if (lk_q.op == `FSW_CMD_WRITE_DISABLE
                       && lk_q.byte_cnt == `FSW_BYTES_OPCODE) begin
            sy_d.write_enable_latch = 1'b0;
          end else if (lk_q.op == `FSW_CMD_WRITE_STATUS) begin
            if (lk_q.byte_cnt == `FSW_BYTES_STATUS_WR && sy_q.write_enable_latch && !hpm_w) begin
              sy_d.busy = fsw_pkg::FSW_BUSY_STATUS;
              sy_d.timer = 24'(TW_CYCLES - 1);
              sy_d.pend = lk_q.wdata;
            end
          end else if ((lk_q.op == `FSW_CMD_CHIP_ERASE_A || lk_q.op == `FSW_CMD_CHIP_ERASE_B)
                       && lk_q.byte_cnt == `FSW_BYTES_OPCODE && sy_q.write_enable_latch) begin
            if (sy_q.bp != 4'h0) begin
              sy_d.write_enable_latch = 1'b0;
            end else begin
              sy_d.busy = fsw_pkg::FSW_BUSY_ARRAY;
              sy_d.pe_start = 1'b1;
              sy_d.pe_op = lk_q.op;
              sy_d.pe_addr = 24'h000000;
            end
          end else if (is_addr_cmd && lk_q.byte_cnt >= `FSW_BYTES_ADDR_CMD && sy_q.write_enable_latch) begin
            if (pe_region_protected_in) begin
              sy_d.write_enable_latch = 1'b0;
            end else begin
              sy_d.busy = fsw_pkg::FSW_BUSY_ARRAY;
              sy_d.pe_start = 1'b1;
              sy_d.pe_op = lk_q.op;
              sy_d.pe_addr = lk_q.addr;
            end
          end else if (clr_only && sy_q.write_enable_latch) begin
            sy_d.write_enable_latch = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sy_q <= '{cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, wp_m: 1'b1, wp_s: 1'b1,
                busy: fsw_pkg::FSW_BUSY_IDLE, default: '0};
    end else begin
      sy_q <= sy_d;
    end
  end
endmodule : fsw_device

/* hw/fsw_host.sv */
// Host controller end: frames commands and collects reply bytes.
`timescale 1ns/1ns
module fsw_host #(
  parameter int HALF = 4
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  fsw_link_if.host link,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [2:0] cmd_tx_bytes_in,
  input wire logic [31:0] cmd_tx_data_in,
  input wire logic [1:0] cmd_rx_bytes_in,
  input wire logic wp_n_in,
  output logic rsp_valid_out,
  output logic [23:0] rsp_data_out
);
  fsw_pkg::fsw_host_st_t h_q;
  fsw_pkg::fsw_host_st_t h_d;
  logic half_end;
  logic [2:0] nbytes;

  assign half_end = h_q.div == 8'(HALF - 1);
  assign nbytes = cmd_tx_bytes_in + {1'b0, cmd_rx_bytes_in};
  assign cmd_ready_out = h_q.st == fsw_pkg::FSW_H_IDLE;
  assign rsp_valid_out = h_q.rsp_v;
  assign rsp_data_out = h_q.rx;
  assign link.cs_n = h_q.cs_n;
  assign link.sck = h_q.sck;
  assign link.mosi = h_q.tx[31];
  assign link.wp_n = h_q.wp_n;

  always_comb begin
    h_d = h_q;
    h_d.rsp_v = 1'b0;
    h_d.miso_m = link.miso;
    h_d.miso_s = h_q.miso_m;
    h_d.wp_n = wp_n_in;
    h_d.div = half_end ? 8'h00 : h_q.div + 8'h01;
    case (h_q.st)
      fsw_pkg::FSW_H_IDLE: begin
        h_d.div = 8'h00;
        if (cmd_valid_in && cmd_tx_bytes_in != 3'h0) begin
          h_d.tx = cmd_tx_data_in;
          h_d.bits = {nbytes, 3'h0};
          h_d.cs_n = 1'b0;
          h_d.st = fsw_pkg::FSW_H_SETUP;
        end
      end
      fsw_pkg::FSW_H_SETUP: begin
        if (half_end) begin
          h_d.sck = 1'b1;
          h_d.st = fsw_pkg::FSW_H_SHIFT;
        end
      end
      fsw_pkg::FSW_H_SHIFT: begin
        if (half_end) begin
          if (h_q.sck) begin
            h_d.rx = {h_q.rx[22:0], h_q.miso_s};
            h_d.sck = 1'b0;
            h_d.tx = {h_q.tx[30:0], 1'b0};
            h_d.bits = h_q.bits - 6'h01;
            if (h_q.bits == 6'h01) begin
              h_d.st = fsw_pkg::FSW_H_HOLD;
            end
          end else begin
            h_d.sck = 1'b1;
          end
        end
      end
      fsw_pkg::FSW_H_HOLD: begin
        if (half_end) begin
          h_d.cs_n = 1'b1;
          h_d.st = fsw_pkg::FSW_H_GAP;
        end
      end
      fsw_pkg::FSW_H_GAP: begin
        if (half_end) begin
          h_d.rsp_v = 1'b1;
          h_d.st = fsw_pkg::FSW_H_IDLE;
        end
      end
      default: begin
        h_d.st = fsw_pkg::FSW_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      h_q <= '{st: fsw_pkg::FSW_H_IDLE, cs_n: 1'b1, wp_n: 1'b1, miso_m: 1'b1, miso_s: 1'b1,
               default: '0};
    end else begin
      h_q <= h_d;
    end
  end
endmodule : fsw_host

/* hw/fsw_link_if.sv */
// Serial link between the host controller and the flash status device.
`timescale 1ns/1ns
interface fsw_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso_d;
  logic miso_oe;
  logic miso;
  logic wp_n;
  assign miso = miso_oe ? miso_d : 1'b1;
  modport dev(input cs_n, input sck, input mosi, input wp_n, output miso_d, output miso_oe);
  modport host(output cs_n, output sck, output mosi, output wp_n, input miso);
endinterface : fsw_link_if

/* hw/fsw_pkg.sv */
// Types shared by both ends of the flash status link.
package fsw_pkg;
  typedef enum logic [1:0] {
    FSW_BUSY_IDLE = 2'h0,
    FSW_BUSY_STATUS = 2'h1,
    FSW_BUSY_ARRAY = 2'h3
  } fsw_busy_t;

  typedef enum logic [2:0] {
    FSW_H_IDLE = 3'h0,
    FSW_H_SETUP = 3'h1,
    FSW_H_SHIFT = 3'h3,
    FSW_H_HOLD = 3'h2,
    FSW_H_GAP = 3'h6
  } fsw_hstate_t;

  typedef struct packed {
    logic tgl;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] wdata;
    logic [23:0] addr;
    logic [7:0] tx;
    logic out_en;
    logic [7:0] st_m;
    logic [7:0] st_s;
  } fsw_link_st_t;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic wp_m;
    logic wp_s;
    logic tgl_m;
    logic tgl_s;
    logic tgl_seen;
    fsw_busy_t busy;
    logic write_enable_latch;
    logic [3:0] bp;
    logic qe;
    logic lock;
    logic [7:0] pend;
    logic [23:0] timer;
    logic pe_start;
    logic [7:0] pe_op;
    logic [23:0] pe_addr;
  } fsw_sys_st_t;

  typedef struct packed {
    fsw_hstate_t st;
    logic [7:0] div;
    logic sck;
    logic cs_n;
    logic wp_n;
    logic [5:0] bits;
    logic [31:0] tx;
    logic [23:0] rx;
    logic rsp_v;
    logic miso_m;
    logic miso_s;
  } fsw_host_st_t;
endpackage : fsw_pkg

/* verif/flash_status_write_protect_test.sv */
// Bench joining the host controller and the flash status device over one link.
`timescale 1ns/1ns
module flash_status_write_protect_test;
  localparam int HALF = 4;
  localparam int TW = 500;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_n = 3'h1;
  logic [31:0] cmd_d = 32'h0;
  logic [1:0] cmd_r = 2'h0;
  logic wp_n = 1'b1;
  logic prot = 1'b0;
  logic done = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic pe_start;
  logic hw_prot;
  logic quad;
  logic [23:0] rsp_data;
  logic [23:0] pe_addr;
  logic [7:0] pe_op;
  logic [7:0] status;
  logic [23:0] exp_q[$];
  logic [23:0] msk_q[$];
  logic [7:0] ops [6] = '{8'h02, 8'h38, 8'h20, 8'h52, 8'hd8, 8'h60};
  logic [3:0] bp;
  logic [23:0] a;
  logic [2:0] n;
  int s0;
  int starts = 0;
  int error_cnt = 0;
  int checks = 0;
  fsw_link_if link();
  fsw_host #(.HALF(HALF)) fsw_host_i (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_tx_bytes_in(cmd_n),
    .cmd_tx_data_in(cmd_d), .cmd_rx_bytes_in(cmd_r), .wp_n_in(wp_n),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data)
  );
  fsw_device #(.TW_NS(TW * 10)) fsw_device_i (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link),
    .pe_region_protected_in(prot), .pe_done_in(done), .pe_start_out(pe_start),
    .pe_opcode_out(pe_op), .pe_addr_out(pe_addr), .status_out(status),
    .hw_protect_out(hw_prot), .quad_mode_out(quad)
  );
  fsw_monitor #(.HALF(HALF)) fsw_monitor_i (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .cs_n_in(link.cs_n), .sck_in(link.sck),
    .mosi_in(link.mosi), .miso_d_in(link.miso_d), .miso_oe_in(link.miso_oe),
    .miso_in(link.miso), .wp_n_in(link.wp_n)
  );
  always #5 sys_clk_in = ~sys_clk_in;
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmd(input logic [2:0] tn, input logic [31:0] d, input logic [1:0] r,
                     input logic [23:0] e);
    exp_q.push_back(e);
    msk_q.push_back(24'hffffff >> (24 - 8 * r));
    cmd_valid <= 1'b1;
    cmd_n <= tn;
    cmd_d <= d;
    cmd_r <= r;
    do @(posedge sys_clk_in); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge sys_clk_in); while (rsp_valid !== 1'b1);
  endtask : cmd
  task automatic op1(input logic [7:0] op);
    cmd(3'h1, {op, 24'h0}, 2'h0, 24'h0);
  endtask : op1
  task automatic rd(input logic [7:0] e);
    cmd(3'h1, 32'h05000000, 2'h1, 24'(e));
  endtask : rd
  task automatic write_status_cmd(input logic [7:0] v);
    cmd(3'h2, {8'h01, v, 16'h0}, 2'h0, 24'h0);
    repeat (TW) @(posedge sys_clk_in);
  endtask : write_status_cmd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  always @(posedge sys_clk_in) begin
    if (pe_start === 1'b1) starts++;
    if (rsp_valid === 1'b1) begin
      cmp(rsp_data & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    error_cnt++;
    stop_test();
  end
  initial begin
    a = 24'($urandom(32'hd5b0));
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(8'h00);
    cmp(24'(status), 24'h0);
    op1(8'h06);
    rd(8'h02);
    op1(8'h04);
    rd(8'h00);
    cmd(3'h1, 32'h9f000000, 2'h3, 24'h5a3c14);
    cmd(3'h1, 32'h9f000000, 2'h1, 24'h00005a);
    $display("test latch and ident done");
    bp = 4'($urandom) | 4'h1;
    op1(8'h06);
    cmd(3'h2, {8'h01, 2'h0, bp, 2'h3, 16'h0}, 2'h0, 24'h0);
    rd(8'h03);
    cmd(3'h1, 32'h9f000000, 2'h3, 24'hffffff);
    repeat (TW) @(posedge sys_clk_in);
    rd({2'h0, bp, 2'h0});
    s0 = starts;
    op1(8'h06);
    op1(8'h60);
    op1(8'h04);
    cmp(24'(starts), 24'(s0));
    op1(8'h06);
    cmd(3'h3, 32'h01000000, 2'h0, 24'h0);
    repeat (TW) @(posedge sys_clk_in);
    rd({2'h0, bp, 2'h2});
    $display("test status write done");
    write_status_cmd({2'h2, bp, 2'h0});
    wp_n <= 1'b0;
    op1(8'h06);
    write_status_cmd(8'h00);
    rd({2'h2, bp, 2'h2});
    cmp(24'(hw_prot), 24'h1);
    wp_n <= 1'b1;
    write_status_cmd(8'h00);
    rd(8'h00);
    op1(8'h06);
    write_status_cmd(8'hc0);
    wp_n <= 1'b0;
    rd(8'hc0);
    cmp(24'(hw_prot), 24'h0);
    cmp(24'(quad), 24'h1);
    op1(8'h06);
    write_status_cmd(8'h00);
    rd(8'h00);
    wp_n <= 1'b1;
    $display("test protection modes done");
    foreach (ops[i]) begin
      s0 = starts;
      a = 24'($urandom);
      n = (ops[i] == 8'h60) ? 3'h1 : 3'h4;
      cmd(n, {ops[i], a}, 2'h0, 24'h0);
      cmp(24'(starts), 24'(s0));
      op1(8'h06);
      prot <= (i == 2);
      cmd(n, {ops[i], a}, 2'h0, 24'h0);
      rd((i == 2) ? 8'h00 : 8'h03);
      cmp(24'(starts - s0), 24'(i != 2));
      if (i != 2) begin
        cmp(24'(pe_op), 24'(ops[i]));
        if (n == 3'h4) cmp(pe_addr, a);
        done <= 1'b1;
        @(posedge sys_clk_in);
        done <= 1'b0;
        rd(8'h00);
      end
    end
    $display("test array commands done");
    stop_test();
  end
endmodule : flash_status_write_protect_test

/* verif/fsw_monitor.sv */
// Checker of the serial link between the host controller and the flash status device.
`timescale 1ns/1ns
module fsw_monitor #(
  parameter int HALF = 4
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_d_in,
  input wire logic miso_oe_in,
  input wire logic miso_in,
  input wire logic wp_n_in
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [5:0] bits_q;
  logic [7:0] hi_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bits_q <= 6'h0;
      hi_q <= 8'h0;
    end else begin
      bits_q <= cs_n_in ? 6'h0 : bits_q + {5'h0, $rose(sck_in)};
      hi_q <= sck_in ? hi_q + 8'h1 : 8'h0;
    end
  end
  sequence gap_s;
    cs_n_in [*5];
  endsequence
  sequence end_frame_s;
    $rose(cs_n_in);
  endsequence
  sck_idle_a: assert property (cs_n_in |-> !sck_in)
    else $error("serial clock runs outside a frame");
  frame_gap_a: assert property (end_frame_s |=> gap_s)
    else $error("select high too short between frames");
  byte_frame_a: assert property (end_frame_s |-> bits_q[2:0] == 3'h0)
    else $error("frame ends off a byte boundary");
  sck_high_a: assert property ($fell(sck_in) |-> hi_q == HALF)
    else $error("serial clock high phase has wrong length");
  mosi_hold_a: assert property (sck_in |-> $stable(mosi_in))
    else $error("host data moves while clock is high");
  miso_hold_a: assert property (sck_in && $past(sck_in) |-> $stable(miso_d_in))
    else $error("device data moves while clock is high");
  miso_select_a: assert property (miso_oe_in |-> !cs_n_in)
    else $error("device drives output while deselected");
  // The rising edge seen at this sample is not yet in the counter.
  miso_after_op_a: assert property (miso_oe_in |->
                                    bits_q + {5'h0, $rose(sck_in)} >= 6'h8)
    else $error("device drives output before the opcode ends");
  miso_release_a: assert property (cs_n_in |-> miso_in)
    else $error("released data line does not read high");
endmodule : fsw_monitor
